/* File: dci_regs.vh */
// Register map and field constants for the converter interface
`ifndef DCI_REGS_VH
`define DCI_REGS_VH

`define DCI_OFF_COMMAND   5'h00
`define DCI_OFF_MODE      5'h04
`define DCI_OFF_HOLDING   5'h08
`define DCI_OFF_OUTPUT    5'h0C
`define DCI_OFF_STATUS    5'h10
`define DCI_OFF_IRQ_SET   5'h14
`define DCI_OFF_IRQ_CLR   5'h18
`define DCI_OFF_IRQ_MASK  5'h1C

`define DCI_ADDR_W        8
`define DCI_CH_SEL_BIT    5
`define DCI_OFF_MSB       4
`define DCI_ALIGN_W       2

`define DCI_SOFT_RST_BIT  0
`define DCI_TRIG_EN_BIT   0
`define DCI_TRIG_SEL_LSB  1
`define DCI_TRIG_SEL_MSB  3
`define DCI_RES_BIT       4
`define DCI_MODE_W        5
`define DCI_READY_BIT     0

`define DCI_DATA_W        10
`define DCI_LOW_BYTE_W    8
`define DCI_TIMER_NUM     6
`define DCI_TIMER_SEL_MAX 3'h5
`define DCI_RES_10        1'b0
`define DCI_RES_8         1'b1

`define DCI_ZERO32        32'h0000_0000
`define DCI_MODE_RST      5'h00
`define DCI_DATA_RST      10'h000

`endif

/* File: dci_top.v */
// Two-channel digital-to-analog converter control with register port
//
// Behaviour
// - Untriggered: output loads one cycle after write
// - Triggered: selected timer rising edge loads output
// - Output register loads from holding register, or from new write data on a timer edge in the same cycle
// - Resolution bit selects 10-bit or 8-bit
// - 8-bit: shift left two, low bits zero
// - DMA uses byte in 8-bit, half-word otherwise
// - Ready flag tracks pending holding value
// - Ready flag can raise an interrupt
// - Command bit 0 one soft-resets; zero ignored
// - Output code maps linearly onto reference range
// - Two identical channels, own output and interrupt
// - Timer select 0..5; codes 11x reserved
// - Ready: 0 pending/reset/untriggered, trigger enable sets
// - Holding and output both read the adjusted value, zero-padded
// - Enable-set sets mask, enable-clear clears it
`timescale 1ns/1ps
`default_nettype none
`include "dci_regs.vh"

module dci_channel #(
    parameter DATA_W = `DCI_DATA_W,
    parameter TIMER_NUM = `DCI_TIMER_NUM
) (
    input wire clk,
    input wire srst,
    input wire [`DCI_OFF_MSB:0] off,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire [TIMER_NUM-1:0] timer_output_a,
    output reg [31:0] read_value,
    output reg [DATA_W-1:0] output_data_r,
    output reg irq_r,
    output reg dma_byte_r
);

    reg [`DCI_MODE_W-1:0] mode_r;
    reg [DATA_W-1:0] holding_r;
    reg ready_r;
    reg mask_r;
    reg xfer_pend_r;
    reg timer_prev_r;

    reg [`DCI_MODE_W-1:0] mode_nxt;
    reg [DATA_W-1:0] holding_nxt;
    reg [DATA_W-1:0] output_nxt;
    reg ready_nxt;
    reg mask_nxt;
    reg xfer_pend_nxt;
    reg [DATA_W-1:0] adj_data;
    reg timer_sel;
    reg timer_rise;
    reg wr_cmd;
    reg wr_mode;
    reg wr_hold;
    reg wr_irq_set;
    reg wr_irq_clr;
    reg soft_rst;
    reg trig_turn_on;
    reg trig_turn_off;

    wire trig_en = mode_r[`DCI_TRIG_EN_BIT];
    wire [2:0] trig_sel = mode_r[`DCI_TRIG_SEL_MSB:`DCI_TRIG_SEL_LSB];
    wire res_8 = (mode_r[`DCI_RES_BIT] == `DCI_RES_8);

    // Zero bits under an 8-bit sample
    localparam PAD_W = DATA_W - `DCI_LOW_BYTE_W;

    // Selected timer level; reserved codes give no trigger
    function sel_timer;
        input [2:0] sel;
        input [TIMER_NUM-1:0] tio;
        begin
            if (sel <= `DCI_TIMER_SEL_MAX) begin
                sel_timer = tio[sel];
            end else begin
                sel_timer = 1'b0;
            end
        end
    endfunction

    // Access aimed at one register offset
    function reg_hit;
        input [`DCI_OFF_MSB:0] cur;
        input [`DCI_OFF_MSB:0] tgt;
        begin
            reg_hit = (cur == tgt);
        end
    endfunction

    // Write decode, one strobe per writable register
    always @* begin
        wr_cmd = wr_en && reg_hit(off, `DCI_OFF_COMMAND);
        wr_mode = wr_en && reg_hit(off, `DCI_OFF_MODE);
        wr_hold = wr_en && reg_hit(off, `DCI_OFF_HOLDING);
        wr_irq_set = wr_en && reg_hit(off, `DCI_OFF_IRQ_SET) && wdata[`DCI_READY_BIT];
        wr_irq_clr = wr_en && reg_hit(off, `DCI_OFF_IRQ_CLR) && wdata[`DCI_READY_BIT];
        soft_rst = wr_cmd && wdata[`DCI_SOFT_RST_BIT];
        trig_turn_on = wr_mode && wdata[`DCI_TRIG_EN_BIT] && !trig_en;
        trig_turn_off = wr_mode && !wdata[`DCI_TRIG_EN_BIT];
    end

    // Write data aligned to the resolution
    always @* begin
        if (res_8) begin
            adj_data = {wdata[`DCI_LOW_BYTE_W-1:0], {PAD_W{1'b0}}};
        end else begin
            adj_data = wdata[DATA_W-1:0];
        end
    end

    // Selected timer and its rising edge
    always @* begin
        timer_sel = sel_timer(trig_sel, timer_output_a);
        timer_rise = trig_en && timer_sel && !timer_prev_r;
    end

    // Mode register
    always @* begin
        mode_nxt = mode_r;
        if (soft_rst) begin
            mode_nxt = `DCI_MODE_RST;
        end else if (wr_mode) begin
            mode_nxt = wdata[`DCI_MODE_W-1:0];
        end
    end

    // Holding register and untriggered transfer request
    always @* begin
        holding_nxt = holding_r;
        xfer_pend_nxt = 1'b0;
        if (soft_rst) begin
            holding_nxt = `DCI_DATA_RST;
        end else if (wr_hold) begin
            holding_nxt = adj_data;
            xfer_pend_nxt = !trig_en;
        end
    end

    // Output register, fed from the holding path, or from new write data on a timer edge
    always @* begin
        output_nxt = output_data_r;
        if (soft_rst) begin
            output_nxt = `DCI_DATA_RST;
        end else if (timer_rise) begin
            // New write in the edge cycle goes straight through
            output_nxt = wr_hold ? adj_data : holding_r;
        end else if (xfer_pend_r && !trig_en) begin
            output_nxt = holding_r;
        end
    end

    // Ready flag; mode writes that turn the trigger on or off outrank a timer edge
    always @* begin
        ready_nxt = ready_r;
        if (soft_rst) begin
            ready_nxt = 1'b0;
        end else if (trig_turn_on) begin
            ready_nxt = 1'b1;
        end else if (trig_turn_off) begin
            ready_nxt = 1'b0;
        end else if (timer_rise) begin
            ready_nxt = 1'b1;
        end else if (wr_hold) begin
            ready_nxt = 1'b0;
        end
    end

    // Interrupt mask
    always @* begin
        mask_nxt = mask_r;
        if (soft_rst) begin
            mask_nxt = 1'b0;
        end else if (wr_irq_set) begin
            mask_nxt = 1'b1;
        end else if (wr_irq_clr) begin
            mask_nxt = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            mode_r <= `DCI_MODE_RST;
            holding_r <= `DCI_DATA_RST;
            output_data_r <= `DCI_DATA_RST;
            ready_r <= 1'b0;
            mask_r <= 1'b0;
            xfer_pend_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            holding_r <= holding_nxt;
            output_data_r <= output_nxt;
            ready_r <= ready_nxt;
            mask_r <= mask_nxt;
            xfer_pend_r <= xfer_pend_nxt;
        end
    end

    // Previous timer sample, kept through soft reset
    always @(posedge clk) begin
        if (srst) begin
            timer_prev_r <= 1'b0;
        end else begin
            timer_prev_r <= timer_sel;
        end
    end

    // Pin-side flags follow the next register state
    always @(posedge clk) begin
        if (srst) begin
            irq_r <= 1'b0;
            dma_byte_r <= 1'b0;
        end else begin
            irq_r <= ready_nxt && mask_nxt;
            dma_byte_r <= (mode_nxt[`DCI_RES_BIT] == `DCI_RES_8);
        end
    end

    always @* begin
        read_value = `DCI_ZERO32;
        case (off)
            `DCI_OFF_MODE: read_value[`DCI_MODE_W-1:0] = mode_r;
            `DCI_OFF_HOLDING: read_value[DATA_W-1:0] = holding_r;
            `DCI_OFF_OUTPUT: read_value[DATA_W-1:0] = output_data_r;
            `DCI_OFF_STATUS: read_value[`DCI_READY_BIT] = ready_r;
            `DCI_OFF_IRQ_MASK: read_value[`DCI_READY_BIT] = mask_r;
            default: read_value = `DCI_ZERO32;
        endcase
    end

endmodule // dci_channel

module dci_top #(
    parameter DATA_W = `DCI_DATA_W,
    parameter TIMER_NUM = `DCI_TIMER_NUM
) (
    input wire clk,
    input wire srst,
    input wire [`DCI_ADDR_W-1:0] addr,
    input wire [31:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [TIMER_NUM-1:0] timer_output_a,
    output reg [31:0] rdata,
    output wire [DATA_W-1:0] analog_out0,
    output wire [DATA_W-1:0] analog_out1,
    output wire ch0_irq,
    output wire ch1_irq,
    output wire dma_byte0,
    output wire dma_byte1
);

    wire [31:0] ch_read [0:1];
    wire [DATA_W-1:0] ch_out [0:1];
    wire [1:0] ch_irq;
    wire [1:0] ch_byte;
    wire [1:0] ch_wr;
    wire ch_idx = addr[`DCI_CH_SEL_BIT];
    // Accesses with stray upper or alignment bits are dropped
    wire addr_ok = ~|addr[`DCI_ADDR_W-1:`DCI_CH_SEL_BIT+1] && ~|addr[`DCI_ALIGN_W-1:0];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_ch
            assign ch_wr[g] = wr_en && addr_ok && (ch_idx == g);
            dci_channel #(
                .DATA_W(DATA_W),
                .TIMER_NUM(TIMER_NUM)
            ) u_ch (
                .clk(clk),
                .srst(srst),
                .off(addr[`DCI_OFF_MSB:0]),
                .wdata(wdata),
                .wr_en(ch_wr[g]),
                .timer_output_a(timer_output_a),
                .read_value(ch_read[g]),
                .output_data_r(ch_out[g]),
                .irq_r(ch_irq[g]),
                .dma_byte_r(ch_byte[g])
            );
        end
    endgenerate

    assign analog_out0 = ch_out[0];
    assign analog_out1 = ch_out[1];
    assign ch0_irq = ch_irq[0];
    assign ch1_irq = ch_irq[1];
    assign dma_byte0 = ch_byte[0];
    assign dma_byte1 = ch_byte[1];

    // Read data valid only in the cycle after the strobe
    always @(posedge clk) begin
        if (srst) begin
            rdata <= `DCI_ZERO32;
        end else if (rd_en && addr_ok) begin
            rdata <= ch_read[ch_idx];
        end else begin
            rdata <= `DCI_ZERO32;
        end
    end

endmodule // dci_top
`default_nettype wire

/* File: dci_top_sva.sv */
// Port-level assertions for the converter interface
`timescale 1ns/1ps
`default_nettype none
module dci_top_sva #(parameter DATA_W = 10, parameter TIMER_NUM = 6) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [TIMER_NUM-1:0] timer_output_a,
    input wire logic [31:0] rdata,
    input wire logic [DATA_W-1:0] analog_out0,
    input wire logic [DATA_W-1:0] analog_out1,
    input wire logic ch0_irq,
    input wire logic ch1_irq,
    input wire logic dma_byte0,
    input wire logic dma_byte1
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    rd_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data outside slot");
    out_src_a: assert property ($changed(analog_out0) |-> $past(wr_en) || $past(wr_en, 2) || $past(|timer_output_a))
        else $error("output moved alone");
    irq_src_a: assert property ($rose(ch0_irq) |-> $past(wr_en) || $past(wr_en, 2) || $past(|timer_output_a))
        else $error("irq rose alone");
    dma_res_a: assert property (wr_en && addr == 8'h04 && wdata[4] |=> ##[0:1] dma_byte0)
        else $error("byte transfer not set");
    soft_rst_a: assert property (wr_en && addr == 8'h00 && wdata[0] |=> ~|analog_out0 && !ch0_irq && !dma_byte0)
        else $error("soft reset missed");
    irq_off_a: assert property (wr_en && addr == 8'h18 && wdata[0] |=> ##[0:1] !ch0_irq)
        else $error("irq not masked");
    untrig_a: assert property (wr_en && addr == 8'h04 && !wdata[0] |=> ##[0:1] !ch0_irq)
        else $error("ready left set");
    ch1_off_a: assert property (wr_en && addr == 8'h38 && wdata[0] |=> ##[0:1] !ch1_irq)
        else $error("ch1 irq not masked");
    cover property ($rose(ch0_irq));
    cover property ($changed(analog_out1));
    cover property (wr_en && addr == 8'h08 && dma_byte0);
endmodule // dci_top_sva
`default_nettype wire

/* File: dci_timer_model.sv */
// Timer-counter outputs in waveform mode, pulsed on request
`timescale 1ns/1ps
`default_nettype none
module dci_timer_model #(parameter int HI_CYC = 3) (
    input wire logic clk,
    input wire logic srst,
    input wire logic go,
    input wire logic [5:0] mask,
    output logic [5:0] timer_output_a = 6'h00
);
    int cnt = 0;
    // One rising edge per chosen output, low again after HI_CYC
    always @(posedge clk) begin
        if (srst || cnt == 1) begin
            timer_output_a <= 6'h00;
            cnt <= 0;
        end else if (go) begin
            timer_output_a <= mask;
            cnt <= HI_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule // dci_timer_model
`default_nettype wire

/* File: tb_dac_digital_interface.sv */
// Testbench for the two-channel converter interface
`timescale 1ns/1ps
`default_nettype none
module tb_dac_digital_interface;
    logic clk = 0, srst = 1, wr_en = 0, rd_en = 0, go = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, exp = 32'h3FC;
    logic [5:0] mask = 6'h00;
    wire [5:0] timer_output_a;
    wire [31:0] rdata;
    wire [9:0] analog_out0, analog_out1;
    wire ch0_irq, ch1_irq, dma_byte0, dma_byte1;
    int failures = 0, samples_checked = 0;
    initial forever #2 clk = ~clk;
    dci_top dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .timer_output_a(timer_output_a), .rdata(rdata), .analog_out0(analog_out0),
        .analog_out1(analog_out1), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq), .dma_byte0(dma_byte0),
        .dma_byte1(dma_byte1));
    dci_timer_model tmr_u (.clk(clk), .srst(srst), .go(go), .mask(mask),
        .timer_output_a(timer_output_a));
    task chk(string n, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task rd(string n, logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(n, rdata, e);
    endtask
    task pulse(logic [5:0] m);
        @(posedge clk);
        mask <= m;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task stop_test;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int i = 4; i <= 16; i += 4) rd("reset", 8'(i), 32'h0);
        rd("mask", 8'h1C, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        repeat (1250) @(posedge clk);
        wr(8'h08, 32'h3A5);
        #1 chk("out early", analog_out0, 32'h0);
        @(posedge clk);
        #1 chk("out", analog_out0, 32'h3A5);
        wr(8'h0C, 32'h111);
        rd("out kept", 8'h0C, 32'h3A5);
        wr(8'h04, 32'h10);
        wr(8'h08, 32'hFF);
        rd("hold 8b", 8'h08, 32'h3FC);
        rd("out 8b", 8'h0C, 32'h3FC);
        chk("dma byte", dma_byte0, 32'h1);
        chk("ch1 idle", analog_out1, 32'h0);
        wr(8'h04, 32'h0);
        rd("mode", 8'h04, 32'h0);
        chk("dma half", dma_byte0, 32'h0);
        $display("test untriggered done");
        for (int s = 0; s < 6; s++) begin
            wr(8'h04, 32'(2 * s + 1));
            rd("armed", 8'h10, 32'h1);
            wr(8'h08, 32'(s + 16));
            pulse(6'h3F ^ (6'h01 << s));
            rd("held", 8'h0C, exp);
            rd("pending", 8'h10, 32'h0);
            pulse(6'h01 << s);
            exp = 32'(s + 16);
            rd("moved", 8'h0C, exp);
        end
        wr(8'h04, 32'hD);
        wr(8'h08, 32'h77);
        pulse(6'h3F);
        rd("reserved", 8'h0C, exp);
        $display("test triggered done");
        wr(8'h14, 32'h1);
        rd("mask set", 8'h1C, 32'h1);
        chk("irq pending", ch0_irq, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h04, 32'h1);
        rd("ready", 8'h10, 32'h1);
        chk("irq", ch0_irq, 32'h1);
        wr(8'h18, 32'h0);
        rd("mask kept", 8'h1C, 32'h1);
        wr(8'h18, 32'h1);
        rd("mask clr", 8'h1C, 32'h0);
        chk("irq off", ch0_irq, 32'h0);
        wr(8'h00, 32'h0);
        rd("no reset", 8'h04, 32'h1);
        wr(8'h00, 32'h1);
        rd("mode rst", 8'h04, 32'h0);
        rd("out rst", 8'h0C, 32'h0);
        wr(8'h28, 32'h200);
        rd("ch1 out", 8'h2C, 32'h200);
        chk("ch0 quiet", analog_out0, 32'h0);
        wr(8'h34, 32'h1);
        wr(8'h24, 32'h11);
        rd("ch1 ready", 8'h30, 32'h1);
        chk("ch1 irq", ch1_irq, 32'h1);
        chk("ch1 dma byte", dma_byte1, 32'h1);
        chk("ch0 irq quiet", ch0_irq, 32'h0);
        wr(8'h38, 32'h1);
        rd("ch1 mask clr", 8'h3C, 32'h0);
        chk("ch1 irq off", ch1_irq, 32'h0);
        $display("test irq reset channel done");
        stop_test;
    end
endmodule // tb_dac_digital_interface
bind dci_top dci_top_sva #(.DATA_W(DATA_W), .TIMER_NUM(TIMER_NUM)) sva_u (.clk(clk),
    .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .timer_output_a(timer_output_a), .rdata(rdata), .analog_out0(analog_out0),
    .analog_out1(analog_out1), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq), .dma_byte0(dma_byte0),
    .dma_byte1(dma_byte1));
`default_nettype wire
